// ---- verilog/edr_pkg.sv ----
package edr_pkg;

    // Target program address width and byte lanes within it
    localparam int PC_W = 24;
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 8;
    localparam int EXT_LSB = 16;

    // I/O port addresses of the debug register set
    localparam logic [7:0] PORT_PENDING = 8'hf2;
    localparam logic [7:0] PORT_CALL_MAP = 8'hf3;
    localparam logic [7:0] PORT_EXT_BANK = 8'hf4;
    localparam logic [7:0] PORT_JUMP_UPPER = 8'hf5;
    localparam logic [7:0] PORT_BP1_EXT = 8'hf6;
    localparam logic [7:0] PORT_BP2_EXT = 8'hf7;
    localparam logic [7:0] PORT_CONTROL = 8'hf8;
    localparam logic [7:0] PORT_COMMAND = 8'hf9;
    localparam logic [7:0] PORT_JUMP_LOW = 8'hfa;
    localparam logic [7:0] PORT_JUMP_HIGH = 8'hfb;
    localparam logic [7:0] PORT_BP1_LOW = 8'hfc;
    localparam logic [7:0] PORT_BP1_HIGH = 8'hfd;
    localparam logic [7:0] PORT_BP2_LOW = 8'hfe;
    localparam logic [7:0] PORT_BP2_HIGH = 8'hff;

    // Interrupt pending bit positions
    localparam int PEND_EXT31 = 0;
    localparam int PEND_EXT30 = 1;
    localparam int PEND_EXT29 = 2;
    localparam int PEND_DIAG = 3;
    localparam int PEND_HALT = 4;
    localparam int PEND_STEP = 5;
    localparam int PEND_BP2 = 6;
    localparam int PEND_BP1 = 7;
    localparam int EXT_IRQ_W = 5;

    // Debug control byte fields
    localparam int CTL_W = 5;
    localparam int CTL_B1R = 0;
    localparam int CTL_B1W = 1;
    localparam int CTL_B2R = 2;
    localparam int CTL_B2W = 3;
    localparam int CTL_STEP = 4;

    // Debug command byte fields
    localparam int CMD_W = 6;
    localparam int CMD_FR = 0;
    localparam int CMD_FI = 1;
    localparam int CMD_FJ = 2;
    localparam int CMD_IM = 3;
    localparam int CMD_SVC = 4;
    localparam int CMD_SE = 5;

    // Service call mapping: 4 select bits, 16-byte steps in a 16-bit vector
    localparam int CALL_MAP_W = 4;
    localparam int CALL_ALIGN = 4;
    localparam int CALL_VEC_W = 16;

    // Values after reset, in stored (complemented) form
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [CALL_MAP_W-1:0] CALL_MAP_RESET = 4'h0;
    localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;
    localparam logic [CMD_W-1:0] CMD_RESET = 6'h10;
    localparam logic [7:0] PEND_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

endpackage

// ---- verilog/edr_break_cmp.sv ----
`timescale 1ns/100ps
module edr_break_cmp #(
    parameter int ADDR_W = 24
) (
    input wire logic [ADDR_W-1:0] i_compare,
    input wire logic [ADDR_W-1:0] i_pc_addr,
    input wire logic i_pc_valid,
    input wire logic i_pc_is_write,
    input wire logic i_on_read,
    input wire logic i_on_write,
    output logic o_hit
);

    logic access_enabled;

    // All three bytes must agree and the access kind must be armed
    assign access_enabled = i_pc_is_write ? i_on_write : i_on_read;
    assign o_hit = i_pc_valid && (i_pc_addr == i_compare) && access_enabled;

endmodule

// ---- verilog/edr_debug_regs.sv ----
`timescale 1ns/100ps
// Functional notes
// - Pending port read returns ext 31,30,29, diagnostics, halt, step, bp2, bp1 from bit 0.
// - Mapping write stores four bits placing service calls on 16-byte steps in 0000-00FF.
// - Extended bank write captures address bits 16 to 23.
// - Extended jump write latches jump bits 16 to 23 while its strobe asserts.
// - Port F6 write loads first breakpoint extended byte; match raises first-breakpoint interrupt.
// - Port F6 read pulses next extended strobe low and returns next PC bits 16-23.
// - Port F7 write loads second breakpoint extended byte; match raises second-breakpoint interrupt.
// - Port F7 read pulses last extended strobe low and returns last PC bits 16-23.
// - Control write pulses control strobe low and loads four breakpoint enable bits and the step enable bit.
// - Control bits enable bp1 read, bp1 write, bp2 read, bp2 write, stepping; zero active.
// - Command write pulses command strobe low and drives the command flip-flops.
// - Command bits zero request reset, interrupt, jump, mask, sequence; bit 4 one enables calls.
// - Port FA write pulses low jump strobe and stores jump low byte.
// - Port FB write pulses high jump strobe and stores jump high byte.
// - Port FC write loads first breakpoint low byte compared with address low byte.
// - Port FC read pulses next low strobe and returns next PC low byte.
// - All written configuration bytes are stored complemented.
// - Port FD write loads first breakpoint high byte compared with address high byte.
// - Port FE write loads second breakpoint low byte compared with address low byte.
// - Port FF write loads second breakpoint high byte compared with address high byte.
// - Port FE read pulses last low strobe and returns last PC low byte.
module edr_debug_regs (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    output logic o_io_rvalid,
    input wire logic [edr_pkg::PC_W-1:0] i_pc_addr,
    input wire logic i_pc_valid,
    input wire logic i_pc_is_write,
    input wire logic [edr_pkg::PC_W-1:0] i_pc_next,
    input wire logic [edr_pkg::PC_W-1:0] i_pc_last,
    input wire logic [edr_pkg::EXT_IRQ_W-1:0] i_ext_irq,
    output logic o_debug_event,
    output logic [edr_pkg::CALL_VEC_W-1:0] o_service_call_base,
    output logic o_service_call_enable,
    output logic [7:0] o_extended_bank,
    output logic [edr_pkg::PC_W-1:0] o_jump_address,
    output logic o_first_break_on_read,
    output logic o_first_break_on_write,
    output logic o_second_break_on_read,
    output logic o_second_break_on_write,
    output logic o_single_step_enable,
    output logic o_forced_reset_request,
    output logic o_forced_interrupt_request,
    output logic o_forced_jump_request,
    output logic o_debug_interrupt_mask,
    output logic o_sequence_enable,
    output logic o_next_pc_ext_read_strobe_n,
    output logic o_last_pc_ext_read_strobe_n,
    output logic o_next_pc_low_read_strobe_n,
    output logic o_last_pc_low_read_strobe_n,
    output logic o_next_pc_high_read_strobe_n,
    output logic o_last_pc_high_read_strobe_n,
    output logic o_debug_control_write_strobe_n,
    output logic o_debug_command_write_strobe_n,
    output logic o_jump_low_write_strobe_n,
    output logic o_jump_high_write_strobe_n,
    output logic o_jump_upper_write_strobe_n
);

    logic [edr_pkg::CALL_MAP_W-1:0] call_map_q;
    logic [7:0] bank_q;
    logic [7:0] jump_low_q;
    logic [7:0] jump_high_q;
    logic [7:0] jump_upper_q;
    logic [7:0] bp1_low_q;
    logic [7:0] bp1_high_q;
    logic [7:0] bp1_ext_q;
    logic [7:0] bp2_low_q;
    logic [7:0] bp2_high_q;
    logic [7:0] bp2_ext_q;
    logic [edr_pkg::CTL_W-1:0] ctl_q;
    logic [edr_pkg::CMD_W-1:0] cmd_q;
    logic [7:0] pending_q;
    logic [7:0] pending_set;
    logic [edr_pkg::EXT_IRQ_W-1:0] irq_meta_q;
    logic [edr_pkg::EXT_IRQ_W-1:0] irq_sync_q;
    logic [7:0] rdata_d;
    logic bp1_hit;
    logic bp2_hit;
    logic step_event;
    logic pend_clear;

    function automatic logic wr_at(input logic [7:0] port);
        wr_at = i_io_wr && (i_io_addr == port);
    endfunction

    function automatic logic rd_at(input logic [7:0] port);
        rd_at = i_io_rd && (i_io_addr == port);
    endfunction

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_io_wr(logic [7:0] port);
        i_io_wr && (i_io_addr == port);
    endsequence

    sequence s_io_rd(logic [7:0] port);
        i_io_rd && (i_io_addr == port);
    endsequence

    // Software writes inverted values, so each byte is stored complemented
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            call_map_q <= edr_pkg::CALL_MAP_RESET;
        end else if (wr_at(edr_pkg::PORT_CALL_MAP)) begin
            call_map_q <= ~i_io_wdata[edr_pkg::CALL_MAP_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            bank_q <= edr_pkg::BYTE_RESET;
        end else if (wr_at(edr_pkg::PORT_EXT_BANK)) begin
            bank_q <= ~i_io_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            jump_low_q <= edr_pkg::BYTE_RESET;
            jump_high_q <= edr_pkg::BYTE_RESET;
            jump_upper_q <= edr_pkg::BYTE_RESET;
        end else begin
            if (wr_at(edr_pkg::PORT_JUMP_LOW)) begin
                jump_low_q <= ~i_io_wdata;
            end
            if (wr_at(edr_pkg::PORT_JUMP_HIGH)) begin
                jump_high_q <= ~i_io_wdata;
            end
            if (wr_at(edr_pkg::PORT_JUMP_UPPER)) begin
                jump_upper_q <= ~i_io_wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            bp1_low_q <= edr_pkg::BYTE_RESET;
            bp1_high_q <= edr_pkg::BYTE_RESET;
            bp1_ext_q <= edr_pkg::BYTE_RESET;
        end else begin
            if (wr_at(edr_pkg::PORT_BP1_LOW)) begin
                bp1_low_q <= ~i_io_wdata;
            end
            if (wr_at(edr_pkg::PORT_BP1_HIGH)) begin
                bp1_high_q <= ~i_io_wdata;
            end
            if (wr_at(edr_pkg::PORT_BP1_EXT)) begin
                bp1_ext_q <= ~i_io_wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            bp2_low_q <= edr_pkg::BYTE_RESET;
            bp2_high_q <= edr_pkg::BYTE_RESET;
            bp2_ext_q <= edr_pkg::BYTE_RESET;
        end else begin
            if (wr_at(edr_pkg::PORT_BP2_LOW)) begin
                bp2_low_q <= ~i_io_wdata;
            end
            if (wr_at(edr_pkg::PORT_BP2_HIGH)) begin
                bp2_high_q <= ~i_io_wdata;
            end
            if (wr_at(edr_pkg::PORT_BP2_EXT)) begin
                bp2_ext_q <= ~i_io_wdata;
            end
        end
    end

    // Stored one means enabled, since software writes zero to enable
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            ctl_q <= edr_pkg::CTL_RESET;
        end else if (wr_at(edr_pkg::PORT_CONTROL)) begin
            ctl_q <= ~i_io_wdata[edr_pkg::CTL_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cmd_q <= edr_pkg::CMD_RESET;
        end else if (wr_at(edr_pkg::PORT_COMMAND)) begin
            cmd_q <= ~i_io_wdata[edr_pkg::CMD_W-1:0];
        end
    end

    // Strobes go low for the one cycle after the access
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_next_pc_ext_read_strobe_n <= 1'b1;
            o_last_pc_ext_read_strobe_n <= 1'b1;
            o_next_pc_low_read_strobe_n <= 1'b1;
            o_last_pc_low_read_strobe_n <= 1'b1;
            o_next_pc_high_read_strobe_n <= 1'b1;
            o_last_pc_high_read_strobe_n <= 1'b1;
            o_debug_control_write_strobe_n <= 1'b1;
            o_debug_command_write_strobe_n <= 1'b1;
            o_jump_low_write_strobe_n <= 1'b1;
            o_jump_high_write_strobe_n <= 1'b1;
            o_jump_upper_write_strobe_n <= 1'b1;
        end else begin
            o_next_pc_ext_read_strobe_n <= !rd_at(edr_pkg::PORT_BP1_EXT);
            o_last_pc_ext_read_strobe_n <= !rd_at(edr_pkg::PORT_BP2_EXT);
            o_next_pc_low_read_strobe_n <= !rd_at(edr_pkg::PORT_BP1_LOW);
            o_last_pc_low_read_strobe_n <= !rd_at(edr_pkg::PORT_BP2_LOW);
            o_next_pc_high_read_strobe_n <= !rd_at(edr_pkg::PORT_BP1_HIGH);
            o_last_pc_high_read_strobe_n <= !rd_at(edr_pkg::PORT_BP2_HIGH);
            o_debug_control_write_strobe_n <= !wr_at(edr_pkg::PORT_CONTROL);
            o_debug_command_write_strobe_n <= !wr_at(edr_pkg::PORT_COMMAND);
            o_jump_low_write_strobe_n <= !wr_at(edr_pkg::PORT_JUMP_LOW);
            o_jump_high_write_strobe_n <= !wr_at(edr_pkg::PORT_JUMP_HIGH);
            o_jump_upper_write_strobe_n <= !wr_at(edr_pkg::PORT_JUMP_UPPER);
        end
    end

    edr_break_cmp #(
        .ADDR_W(edr_pkg::PC_W)
    ) u_first_breakpoint (
        .i_compare({bp1_ext_q, bp1_high_q, bp1_low_q}),
        .i_pc_addr(i_pc_addr),
        .i_pc_valid(i_pc_valid),
        .i_pc_is_write(i_pc_is_write),
        .i_on_read(ctl_q[edr_pkg::CTL_B1R]),
        .i_on_write(ctl_q[edr_pkg::CTL_B1W]),
        .o_hit(bp1_hit)
    );

    edr_break_cmp #(
        .ADDR_W(edr_pkg::PC_W)
    ) u_second_breakpoint (
        .i_compare({bp2_ext_q, bp2_high_q, bp2_low_q}),
        .i_pc_addr(i_pc_addr),
        .i_pc_valid(i_pc_valid),
        .i_pc_is_write(i_pc_is_write),
        .i_on_read(ctl_q[edr_pkg::CTL_B2R]),
        .i_on_write(ctl_q[edr_pkg::CTL_B2W]),
        .o_hit(bp2_hit)
    );

    // External interrupt lines come from pins, so they are synchronised first
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_meta_q <= '0;
            irq_sync_q <= '0;
        end else begin
            irq_meta_q <= i_ext_irq;
            irq_sync_q <= irq_meta_q;
        end
    end

    assign step_event = i_pc_valid && ctl_q[edr_pkg::CTL_STEP];
    assign pend_clear = rd_at(edr_pkg::PORT_PENDING);

    always_comb begin
        pending_set = '0;
        pending_set[edr_pkg::EXT_IRQ_W-1:0] = irq_sync_q;
        pending_set[edr_pkg::PEND_STEP] = step_event;
        pending_set[edr_pkg::PEND_BP2] = bp2_hit;
        pending_set[edr_pkg::PEND_BP1] = bp1_hit;
    end

    // Sticky; a read clears, but an event in the same cycle survives the clear
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            pending_q <= edr_pkg::PEND_RESET;
        end else begin
            pending_q <= (pending_q & {8{!pend_clear}}) | pending_set;
        end
    end

    // Mask only hides the debug events; they keep collecting as pending
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_debug_event <= 1'b0;
        end else begin
            o_debug_event <= (|pending_q[edr_pkg::PEND_BP1:edr_pkg::PEND_STEP]) && !cmd_q[edr_pkg::CMD_IM];
        end
    end

    always_comb begin
        rdata_d = edr_pkg::RDATA_UNMAPPED;
        case (i_io_addr)
            edr_pkg::PORT_PENDING: rdata_d = pending_q;
            edr_pkg::PORT_BP1_EXT: rdata_d = i_pc_next[edr_pkg::EXT_LSB +: 8];
            edr_pkg::PORT_BP2_EXT: rdata_d = i_pc_last[edr_pkg::EXT_LSB +: 8];
            edr_pkg::PORT_BP1_LOW: rdata_d = i_pc_next[edr_pkg::LOW_LSB +: 8];
            edr_pkg::PORT_BP1_HIGH: rdata_d = i_pc_next[edr_pkg::HIGH_LSB +: 8];
            edr_pkg::PORT_BP2_LOW: rdata_d = i_pc_last[edr_pkg::LOW_LSB +: 8];
            edr_pkg::PORT_BP2_HIGH: rdata_d = i_pc_last[edr_pkg::HIGH_LSB +: 8];
            default: rdata_d = edr_pkg::RDATA_UNMAPPED;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_io_rdata <= edr_pkg::RDATA_UNMAPPED;
            o_io_rvalid <= 1'b0;
        end else begin
            o_io_rvalid <= i_io_rd;
            if (i_io_rd) begin
                o_io_rdata <= rdata_d;
            end
        end
    end

    assign o_service_call_base = {{(edr_pkg::CALL_VEC_W - edr_pkg::CALL_MAP_W - edr_pkg::CALL_ALIGN){1'b0}},
                                  call_map_q, {edr_pkg::CALL_ALIGN{1'b0}}};
    assign o_service_call_enable = !cmd_q[edr_pkg::CMD_SVC];
    assign o_extended_bank = bank_q;
    assign o_jump_address = {jump_upper_q, jump_high_q, jump_low_q};
    assign o_first_break_on_read = ctl_q[edr_pkg::CTL_B1R];
    assign o_first_break_on_write = ctl_q[edr_pkg::CTL_B1W];
    assign o_second_break_on_read = ctl_q[edr_pkg::CTL_B2R];
    assign o_second_break_on_write = ctl_q[edr_pkg::CTL_B2W];
    assign o_single_step_enable = ctl_q[edr_pkg::CTL_STEP];
    assign o_forced_reset_request = cmd_q[edr_pkg::CMD_FR];
    assign o_forced_interrupt_request = cmd_q[edr_pkg::CMD_FI];
    assign o_forced_jump_request = cmd_q[edr_pkg::CMD_FJ];
    assign o_debug_interrupt_mask = cmd_q[edr_pkg::CMD_IM];
    assign o_sequence_enable = cmd_q[edr_pkg::CMD_SE];

    AST_PENDING_READ: assert property (s_io_rd(edr_pkg::PORT_PENDING) |=>
        o_io_rvalid && (o_io_rdata == $past(pending_q)))
        else $error("pending read returned wrong byte");
    AST_CALL_MAP: assert property (s_io_wr(edr_pkg::PORT_CALL_MAP) |=>
        o_service_call_base == {8'h00, ~$past(i_io_wdata[3:0]), 4'h0})
        else $error("service call base not placed from complemented select");
    AST_EXT_BANK: assert property (s_io_wr(edr_pkg::PORT_EXT_BANK) |=>
        o_extended_bank == ~$past(i_io_wdata))
        else $error("extended bank not captured complemented");
    AST_JUMP_UPPER: assert property (s_io_wr(edr_pkg::PORT_JUMP_UPPER) |=>
        !o_jump_upper_write_strobe_n && (o_jump_address[23:16] == ~$past(i_io_wdata)) ##1
        (o_jump_upper_write_strobe_n != $past(i_io_wr && (i_io_addr == edr_pkg::PORT_JUMP_UPPER))))
        else $error("upper jump byte or strobe wrong");
    AST_BP1_HIT: assert property ((i_pc_valid && !i_pc_is_write && ctl_q[0]
        && i_pc_addr == {bp1_ext_q, bp1_high_q, bp1_low_q}) |=> pending_q[7])
        else $error("first breakpoint read match not pending");
    AST_BP2_MISS: assert property ((i_pc_valid && i_pc_is_write && !ctl_q[3] && !pend_clear
        && !pending_q[6]) |=> !pending_q[6])
        else $error("second breakpoint fired while write disabled");
    AST_NEXT_EXT_READ: assert property (s_io_rd(edr_pkg::PORT_BP1_EXT) |=>
        !o_next_pc_ext_read_strobe_n && (o_io_rdata == $past(i_pc_next[23:16])))
        else $error("next extended read wrong");
    AST_LAST_EXT_READ: assert property (s_io_rd(edr_pkg::PORT_BP2_EXT) |=>
        !o_last_pc_ext_read_strobe_n && (o_io_rdata == $past(i_pc_last[23:16])))
        else $error("last extended read wrong");
    AST_LOW_READS: assert property ((s_io_rd(edr_pkg::PORT_BP1_LOW) |=> !o_next_pc_low_read_strobe_n
        && o_io_rdata == $past(i_pc_next[7:0])) and (s_io_rd(edr_pkg::PORT_BP2_LOW) |=>
        !o_last_pc_low_read_strobe_n && o_io_rdata == $past(i_pc_last[7:0])))
        else $error("low byte PC read wrong");
    AST_CONTROL: assert property (s_io_wr(edr_pkg::PORT_CONTROL) |=>
        !o_debug_control_write_strobe_n && (o_single_step_enable == !$past(i_io_wdata[4]))
        && (o_first_break_on_read == !$past(i_io_wdata[0])))
        else $error("control byte not applied active low");
    AST_COMMAND: assert property (s_io_wr(edr_pkg::PORT_COMMAND) |=>
        !o_debug_command_write_strobe_n && (o_forced_reset_request == !$past(i_io_wdata[0]))
        && (o_service_call_enable == $past(i_io_wdata[4])) && (o_sequence_enable == !$past(i_io_wdata[5])))
        else $error("command byte decoded wrong");
    AST_JUMP_LOW_HIGH: assert property ((s_io_wr(edr_pkg::PORT_JUMP_LOW) |=>
        !o_jump_low_write_strobe_n && o_jump_address[7:0] == ~$past(i_io_wdata)) and
        (s_io_wr(edr_pkg::PORT_JUMP_HIGH) |=> !o_jump_high_write_strobe_n
        && o_jump_address[15:8] == ~$past(i_io_wdata)))
        else $error("jump low or high byte wrong");
    AST_MASK: assert property ((pending_q[7:5] != 3'h0) && cmd_q[3] |=> !o_debug_event)
        else $error("masked debug event was signalled");
    AST_STICKY: assert property (pending_q[7] && !pend_clear |=> pending_q[7])
        else $error("first breakpoint pending dropped without a read");

endmodule

// ---- verif/edr_target_model.sv ----
`timescale 1ns/100ps
module edr_target_model (
    input wire logic i_sys_clk,
    output logic [23:0] o_pc_addr,
    output logic o_pc_valid,
    output logic o_pc_is_write,
    output logic [23:0] o_pc_next,
    output logic [23:0] o_pc_last
);
    initial begin
        o_pc_addr = 24'h000000;
        o_pc_valid = 1'b0;
        o_pc_is_write = 1'b0;
        o_pc_next = 24'h000001;
        o_pc_last = 24'h000000;
    end
    // Idle bus shows the inverse of the last access so a stale address can never match
    task automatic access(input logic [23:0] a, input logic w);
        @(posedge i_sys_clk) #1;
        o_pc_addr = a;
        o_pc_is_write = w;
        o_pc_valid = 1'b1;
        @(posedge i_sys_clk) #1;
        o_pc_valid = 1'b0;
        o_pc_addr = ~a;
        o_pc_is_write = ~w;
        o_pc_last = a;
        o_pc_next = a + 24'h000001;
    endtask
endmodule

// ---- verif/edr_debug_regs_tb_top.sv ----
`timescale 1ns/100ps
module edr_debug_regs_tb_top;
    logic i_sys_clk, i_reset, i_io_wr, i_io_rd, o_io_rvalid, o_debug_event, o_service_call_enable;
    logic i_pc_valid, i_pc_is_write;
    logic [7:0] i_io_addr, i_io_wdata, o_io_rdata, o_extended_bank, d, pe;
    logic [23:0] i_pc_addr, i_pc_next, i_pc_last, o_jump_address, j, la, nxp;
    logic [15:0] o_service_call_base;
    logic [4:0] i_ext_irq, ctl, cmd, ws;
    logic [5:0] rs;
    logic [16:0] lf = 17'h14c2a;
    int n_errors = 0;
    int n_tests = 0;
    edr_debug_regs u_edr_debug_regs (
        .i_sys_clk, .i_reset, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata, .o_io_rvalid,
        .i_pc_addr, .i_pc_valid, .i_pc_is_write, .i_pc_next, .i_pc_last, .i_ext_irq, .o_debug_event,
        .o_service_call_base, .o_service_call_enable, .o_extended_bank, .o_jump_address,
        .o_first_break_on_read(ctl[0]), .o_first_break_on_write(ctl[1]), .o_second_break_on_read(ctl[2]),
        .o_second_break_on_write(ctl[3]), .o_single_step_enable(ctl[4]), .o_forced_reset_request(cmd[0]),
        .o_forced_interrupt_request(cmd[1]), .o_forced_jump_request(cmd[2]), .o_debug_interrupt_mask(cmd[3]),
        .o_sequence_enable(cmd[4]), .o_next_pc_ext_read_strobe_n(rs[0]), .o_last_pc_ext_read_strobe_n(rs[1]),
        .o_next_pc_low_read_strobe_n(rs[2]), .o_last_pc_low_read_strobe_n(rs[3]),
        .o_next_pc_high_read_strobe_n(rs[4]), .o_last_pc_high_read_strobe_n(rs[5]),
        .o_debug_control_write_strobe_n(ws[0]), .o_debug_command_write_strobe_n(ws[1]),
        .o_jump_low_write_strobe_n(ws[2]), .o_jump_high_write_strobe_n(ws[3]), .o_jump_upper_write_strobe_n(ws[4])
    );
    edr_target_model u_edr_target_model (.i_sys_clk, .o_pc_addr(i_pc_addr), .o_pc_valid(i_pc_valid),
        .o_pc_is_write(i_pc_is_write), .o_pc_next(i_pc_next), .o_pc_last(i_pc_last));
    function automatic logic [7:0] rb();
        lf = {lf[15:0], lf[16] ^ lf[13]};
        return lf[7:0];
    endfunction
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dt, input logic [4:0] ex);
        @(posedge i_sys_clk) #1;
        i_io_addr = a;
        i_io_wdata = dt;
        i_io_wr = 1'b1;
        @(posedge i_sys_clk) #1;
        i_io_wr = 1'b0;
        chk("wstrobe", {rs, ws}, {6'h3f, ex});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [5:0] rx);
        @(posedge i_sys_clk) #1;
        i_io_addr = a;
        i_io_rd = 1'b1;
        @(posedge i_sys_clk) #1;
        i_io_rd = 1'b0;
        chk("rdata", o_io_rdata, ex);
        chk("rstrobe", {rs, o_io_rvalid}, {rx, 1'b1});
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #20000;
        n_errors++;
        complete_run();
    end
    initial begin
        {i_reset, i_io_wr, i_io_rd, i_io_addr, i_io_wdata, i_ext_irq} = {3'h4, 16'h0000, 5'h00};
        repeat (3) @(posedge i_sys_clk);
        #1 i_reset = 1'b0;
        repeat (4) begin
            d = rb();
            j = {rb(), rb(), rb()};
            wr(8'hf4, d, 5'h1f);
            // Braces keep the inversion at byte width before the 24-bit compare widens it
            chk("bank", o_extended_bank, {~d});
            wr(8'hf3, d, 5'h1f);
            chk("callmap", o_service_call_base, {8'h00, ~d[3:0], 4'h0});
            wr(8'hf8, d, 5'h1e);
            chk("control", ctl, {~d[4:0]});
            wr(8'hf9, d, 5'h1d);
            chk("command", {o_service_call_enable, cmd}, {d[4], ~d[5], ~d[3:0]});
            wr(8'hfa, j[7:0], 5'h1b);
            wr(8'hfb, j[15:8], 5'h17);
            wr(8'hf5, j[23:16], 5'h0f);
            chk("jump", o_jump_address, ~j);
        end
        // Everything disabled so pin events are the only pending sources
        wr(8'hf8, 8'h1f, 5'h1e);
        wr(8'hf9, 8'h2f, 5'h1d);
        rd(8'hf2, 8'h00, 6'h3f);
        d = rb();
        i_ext_irq = d[4:0];
        repeat (4) @(posedge i_sys_clk);
        #1 i_ext_irq = 5'h00;
        repeat (4) @(posedge i_sys_clk);
        rd(8'hf2, {3'h0, d[4:0]}, 6'h3f);
        rd(8'hf3, 8'h00, 6'h3f);
        la = {rb(), rb(), rb()};
        nxp = la + 24'h000001;
        u_edr_target_model.access(la, 1'b0);
        rd(8'hf6, nxp[23:16], 6'h3e);
        rd(8'hf7, la[23:16], 6'h3d);
        rd(8'hfc, nxp[7:0], 6'h3b);
        rd(8'hfe, la[7:0], 6'h37);
        rd(8'hfd, nxp[15:8], 6'h2f);
        wr(8'hfc, ~la[7:0], 5'h1f);
        wr(8'hfd, ~la[15:8], 5'h1f);
        wr(8'hf6, ~la[23:16], 5'h1f);
        wr(8'hfe, ~la[7:0], 5'h1f);
        wr(8'hff, ~la[15:8] ^ 8'h01, 5'h1f);
        wr(8'hf7, ~la[23:16], 5'h1f);
        wr(8'hf8, 8'h16, 5'h1e);
        for (int i = 0; i < 7; i++) begin
            if (i == 6) wr(8'hf9, 8'h27, 5'h1d);
            j = la ^ (i inside {2, 3} ? 24'h000100 : i == 4 ? 24'h000001 : i == 5 ? 24'h010000 : 24'h000000);
            pe = (i == 0 || i == 6) ? 8'h80 : (i == 2) ? 8'h40 : 8'h00;
            u_edr_target_model.access(j, i inside {1, 2});
            @(posedge i_sys_clk) #1;
            chk("event", o_debug_event, pe != 8'h00 && i != 6);
            rd(8'hf2, pe, 6'h3f);
        end
        complete_run();
    end
endmodule
